/* File: emc_regs.vh */
`ifndef EMC_REGS_VH
`define EMC_REGS_VH

// Register indices as printed in the special-function space.
`define EMC_PAGE_IDX        8'haa
`define EMC_CFG_IDX         8'hab

// APB byte addresses are four times the index.
`define EMC_PAGE_ADDR       12'h2a8
`define EMC_CFG_ADDR        12'h2ac
`define EMC_ADDR_W          12

// Reset values.
`define EMC_PAGE_RST        8'h00
`define EMC_CFG_RST         8'h03

// Configuration field positions.
`define EMC_CFG_DEMUX_BIT   4
`define EMC_CFG_MODE_HI     3
`define EMC_CFG_MODE_LO     2
`define EMC_CFG_ALE_HI      1
`define EMC_CFG_ALE_LO      0

// Only bits 4:0 of the configuration register are stored.
`define EMC_CFG_WMASK       8'h1f

// Memory mode encodings.
`define EMC_MODE_INTERNAL   2'h0
`define EMC_MODE_SPLIT_PORT 2'h1
`define EMC_MODE_SPLIT_PAGE 2'h2
`define EMC_MODE_EXTERNAL   2'h3

// Default on-chip data space size in bytes.
`define EMC_ONCHIP_BYTES    17'h01000

// Default strobe width in system clock cycles.
`define EMC_STROBE_CYC      4'h4

// Cycles from a pin change to its synchronised copy.
`define EMC_SYNC_DEPTH      2

`endif

/* File: emc_port_cfg.v */
`timescale 1ns/1ps
`include "emc_regs.vh"
module emc_port_cfg #(
  parameter [16:0] ONCHIP_BYTES = `EMC_ONCHIP_BYTES,
  parameter [3:0]  STROBE_CYC   = `EMC_STROBE_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        external_move_instruction_req,
  input  wire        external_move_instruction_write,
  input  wire        external_move_instruction_short,
  input  wire [15:0] external_move_instruction_addr,
  input  wire [7:0]  external_move_instruction_wdata,
  input  wire [7:0]  addr_hi_latch,
  output wire        external_move_instruction_busy,
  output reg         external_move_instruction_done,
  output reg  [7:0]  external_move_instruction_rdata,
  output reg         onchip_sel,
  output reg  [15:0] onchip_addr,
  output reg         pins_owned,
  output reg  [7:0]  addr_hi_out,
  output reg         addr_hi_oe,
  output reg  [7:0]  addr_lo_out,
  output reg         addr_lo_oe,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output reg         data_oe,
  output reg         ale_out,
  output reg         rd_n_out,
  output reg         wr_n_out,
  output reg         strobe_oe
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ALEH  = 6'h02;
  localparam [5:0] S_ALEL  = 6'h04;
  localparam [5:0] S_STRB  = 6'h08;
  localparam [5:0] S_DONE  = 6'h10;
  localparam [5:0] S_LOCAL = 6'h20;

  // Only the low five bits of the reset value have storage behind them.
  localparam [7:0] CFG_RST_STORED = `EMC_CFG_RST & `EMC_CFG_WMASK;

  reg  [7:0]  page_q;
  reg  [4:0]  cfg_q;
  reg  [5:0]  state_q;
  reg  [5:0]  state_d;
  reg  [3:0]  cnt_q;
  reg  [3:0]  cnt_d;
  reg  [15:0] eaddr_q;
  reg         wr_q;
  reg  [7:0]  wdata_q;
  reg  [7:0]  din_meta_q;
  reg  [7:0]  din_sync_q;

  wire        acc_setup;
  wire        acc_done;
  wire        hit_page;
  wire        hit_cfg;
  wire [7:0]  cfg_read;
  wire        demux;
  wire [1:0]  mode;
  wire [3:0]  ale_cyc;
  wire [7:0]  hi_byte;
  wire [15:0] eaddr;
  wire [16:0] eaddr_ext;
  reg         offchip;
  wire        start;

  // APB slave: registers answer with no wait state.
  assign pready    = 1'b1;
  assign acc_setup = psel & ~penable;
  assign acc_done  = psel & penable;
  assign hit_page  = (paddr == `EMC_PAGE_ADDR);
  assign hit_cfg   = (paddr == `EMC_CFG_ADDR);
  // An unmapped address answers with an error, and its write falls away.
  assign pslverr   = acc_done & ~hit_page & ~hit_cfg;

  // Bits 7:5 are not stored, so they always read as zero.
  assign cfg_read = {3'h0, cfg_q};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_q <= `EMC_PAGE_RST;
      cfg_q  <= CFG_RST_STORED[4:0];
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      // Read data is loaded in the setup cycle only when clk_en is high; no wait state is inserted when it is low.
      if (acc_setup)
      begin
        if (hit_page)
          prdata <= {24'h00_0000, page_q};
        else if (hit_cfg)
          prdata <= {24'h00_0000, cfg_read};
        else
          prdata <= 32'h0000_0000;
      end
      if (acc_done && pwrite)
      begin
        if (hit_page)
          page_q <= pwdata[7:0];
        if (hit_cfg)
          cfg_q <= pwdata[4:0];
      end
    end
  end

  assign demux   = cfg_q[`EMC_CFG_DEMUX_BIT];
  assign mode    = cfg_q[`EMC_CFG_MODE_HI:`EMC_CFG_MODE_LO];
  assign ale_cyc = {2'h0, cfg_q[`EMC_CFG_ALE_HI:`EMC_CFG_ALE_LO]} + 4'h1;

  // Short moves take the upper byte from the page register, or in split mode
  // without bank select from the address-high port latches.
  assign hi_byte = (mode == `EMC_MODE_SPLIT_PORT) ? addr_hi_latch : page_q;
  assign eaddr   = external_move_instruction_short ? {hi_byte, external_move_instruction_addr[7:0]} : external_move_instruction_addr;
  assign eaddr_ext = {1'b0, eaddr};

  always @*
  begin
    // In the split modes the boundary address itself is the first off-chip one.
    case (mode)
      `EMC_MODE_INTERNAL: offchip = 1'b0;
      `EMC_MODE_EXTERNAL: offchip = 1'b1;
      default:            offchip = (eaddr_ext >= ONCHIP_BYTES);
    endcase
  end

  assign start     = external_move_instruction_req & state_q[0];
  // The core must hold a request while busy; nothing here queues it.
  assign external_move_instruction_busy = ~state_q[0];

  // Next-state logic. Strobe must outlast the input synchroniser so that read
  // data sampled at its end is the value present while the strobe was low.
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE:
      begin
        if (start)
        begin
          if (!offchip)
            state_d = S_LOCAL;
          else if (!demux)
          begin
            state_d = S_ALEH;
            cnt_d   = ale_cyc - 4'h1;
          end
          else
          begin
            state_d = S_STRB;
            cnt_d   = STROBE_CYC - 4'h1;
          end
        end
      end
      S_ALEH:
      begin
        if (cnt_q == 4'h0)
        begin
          state_d = S_ALEL;
          cnt_d   = ale_cyc - 4'h1;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      S_ALEL:
      begin
        if (cnt_q == 4'h0)
        begin
          state_d = S_STRB;
          cnt_d   = STROBE_CYC - 4'h1;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      S_STRB:
      begin
        if (cnt_q == 4'h0)
          state_d = S_DONE;
        else
          cnt_d = cnt_q - 4'h1;
      end
      S_DONE:
        state_d = S_IDLE;
      S_LOCAL:
        state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      eaddr_q    <= 16'h0000;
      wr_q       <= 1'b0;
      wdata_q    <= 8'h00;
      din_meta_q <= 8'h00;
      din_sync_q <= 8'h00;
    end
    else if (clk_en)
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      // The synchroniser freezes with the rest, so a read paused by a low clock
      // enable still samples data from inside its own strobe.
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
      if (start)
      begin
        eaddr_q <= eaddr;
        wr_q    <= external_move_instruction_write;
        wdata_q <= external_move_instruction_wdata;
      end
    end
  end

  // Pin drive and completion outputs, all registered.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_owned  <= 1'b0;
      addr_hi_out <= 8'h00;
      addr_hi_oe  <= 1'b0;
      addr_lo_out <= 8'h00;
      addr_lo_oe  <= 1'b0;
      data_out    <= 8'h00;
      data_oe     <= 1'b0;
      ale_out     <= 1'b0;
      rd_n_out    <= 1'b1;
      wr_n_out    <= 1'b1;
      strobe_oe   <= 1'b0;
      external_move_instruction_done   <= 1'b0;
      external_move_instruction_rdata  <= 8'h00;
      onchip_sel  <= 1'b0;
      onchip_addr <= 16'h0000;
    end
    else if (clk_en)
    begin
      external_move_instruction_done  <= 1'b0;
      onchip_sel <= 1'b0;
      case (state_d)
        S_ALEH:
        begin
          pins_owned  <= 1'b1;
          strobe_oe   <= 1'b1;
          addr_hi_oe  <= 1'b1;
          addr_hi_out <= start ? eaddr[15:8] : eaddr_q[15:8];
          ale_out     <= 1'b1;
          data_out    <= start ? eaddr[7:0] : eaddr_q[7:0];
          data_oe     <= 1'b1;
        end
        S_ALEL:
        begin
          ale_out <= 1'b0;
          data_oe <= 1'b0;
        end
        S_STRB:
        begin
          pins_owned  <= 1'b1;
          strobe_oe   <= 1'b1;
          addr_hi_oe  <= 1'b1;
          addr_hi_out <= start ? eaddr[15:8] : eaddr_q[15:8];
          addr_lo_oe  <= demux;
          addr_lo_out <= start ? eaddr[7:0] : eaddr_q[7:0];
          rd_n_out    <= start ? external_move_instruction_write : wr_q;
          wr_n_out    <= start ? ~external_move_instruction_write : ~wr_q;
          data_out    <= start ? external_move_instruction_wdata : wdata_q;
          data_oe     <= start ? external_move_instruction_write : wr_q;
        end
        S_DONE:
        begin
          rd_n_out   <= 1'b1;
          wr_n_out   <= 1'b1;
          data_oe    <= 1'b0;
          external_move_instruction_done  <= 1'b1;
          // The synchronised byte left the pins two enabled cycles ago, while the
          // read strobe was still low.
          if (!wr_q)
            external_move_instruction_rdata <= din_sync_q;
        end
        S_LOCAL:
        begin
          // Internal-only mode aliases every address into on-chip space.
          onchip_sel  <= 1'b1;
          onchip_addr <= eaddr & (ONCHIP_BYTES[15:0] - 16'h0001);
          external_move_instruction_done   <= 1'b1;
        end
        default:
        begin
          // Releasing every enable hands the pins back to the port logic.
          pins_owned <= 1'b0;
          addr_hi_oe <= 1'b0;
          addr_lo_oe <= 1'b0;
          data_oe    <= 1'b0;
          strobe_oe  <= 1'b0;
          ale_out    <= 1'b0;
          rd_n_out   <= 1'b1;
          wr_n_out   <= 1'b1;
        end
      endcase
    end
  end

  // Drive type of each pin stays with the port output-mode logic; this block
  // offers only levels and enables.

endmodule

/* File: emc_sram_model.sv */
`timescale 1ns/1ps
module emc_sram_model (
  input  logic        pclk,
  input  logic        muxed,
  input  logic        ale,
  input  logic        rd_n,
  input  logic        wr_n,
  input  logic [7:0]  a_hi,
  input  logic [7:0]  a_lo,
  input  logic [7:0]  dq_o,
  output logic [7:0]  dq_i,
  output logic [15:0] last_a,
  output logic [7:0]  last_d
);
  logic [7:0] lat_q;
  logic [7:0] t_q = 8'h00;
  wire  [15:0] a = {a_hi, muxed ? lat_q : a_lo};
  always @(posedge pclk)
  begin
    t_q <= t_q + 8'h01;
    if (ale)
      lat_q <= dq_o;
    if (!rd_n)
      last_a <= a;
    if (!wr_n)
    begin
      last_a <= a;
      last_d <= dq_o;
    end
    // Outside a read the lines change every cycle, so stale data cannot pass.
    dq_i <= !rd_n ? a[7:0] ^ a[15:8] : t_q;
  end
endmodule

/* File: emc_port_cfg_properties.sv */
`timescale 1ns/1ps
`include "emc_regs.vh"
module emc_port_cfg_chk #(
  parameter [3:0] STROBE_CYC = 4'h4
) (
  input logic        pclk,
  input logic        presetn,
  input logic        clk_en,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pslverr,
  input logic        external_move_instruction_done,
  input logic        pins_owned,
  input logic        data_oe,
  input logic        addr_hi_oe,
  input logic        strobe_oe,
  input logic        ale_out,
  input logic        rd_n_out,
  input logic        wr_n_out
);
  logic [3:0] cnt_q;
  wire        strb = rd_n_out & wr_n_out;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 4'h0;
    else if (clk_en)
      cnt_q <= strb ? 4'h0 : cnt_q + 4'h1;
  a_idle_pins_free: assert property (!pins_owned |-> !data_oe && !addr_hi_oe && !strobe_oe)
    else $error("pins driven while not owned");
  a_done_release: assert property (external_move_instruction_done && clk_en |=> !pins_owned && !external_move_instruction_done)
    else $error("pins kept after move");
  a_read_float: assert property (!rd_n_out |-> !data_oe)
    else $error("data driven during read");
  a_write_drive: assert property (!wr_n_out |-> data_oe && addr_hi_oe)
    else $error("write without drivers");
  a_ale_first: assert property (ale_out |-> strb && pins_owned)
    else $error("latch overlaps strobe");
  a_strobe_len: assert property ($rose(strb) |-> cnt_q == STROBE_CYC)
    else $error("strobe width wrong");
  a_strobe_owned: assert property (!strb |-> pins_owned && strobe_oe)
    else $error("strobe without ownership");
  a_unmapped_err: assert property (psel && penable |->
    pslverr == !(paddr == `EMC_PAGE_ADDR || paddr == `EMC_CFG_ADDR))
    else $error("error response wrong");
  cover property (!rd_n_out);
  cover property (!wr_n_out);
  cover property (ale_out);
  cover property (pslverr);
  cover property (!clk_en && pins_owned);
endmodule
bind emc_port_cfg emc_port_cfg_chk #(.STROBE_CYC(STROBE_CYC)) u_chk (.pclk, .presetn, .clk_en,
  .psel, .penable, .paddr, .pslverr, .external_move_instruction_done, .pins_owned, .data_oe, .addr_hi_oe,
  .strobe_oe, .ale_out, .rd_n_out, .wr_n_out);

/* File: emc_port_cfg_bench.sv */
`timescale 1ns/1ps
`include "emc_regs.vh"
module emc_port_cfg_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic external_move_instruction_req = 0, external_move_instruction_write = 0, external_move_instruction_short = 0, err, clk_en = 1, frz = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, rd, lfsr = 32'hfb535bcd;
  logic [15:0] external_move_instruction_addr = 0, onchip_addr, last_a, e;
  logic [7:0] external_move_instruction_wdata = 0, addr_hi_latch = 0, cfg = 8'h03, page = 0;
  logic [7:0] external_move_instruction_rdata, addr_hi_out, addr_lo_out, data_out, dq_i, last_d;
  logic pready, pslverr, external_move_instruction_busy, external_move_instruction_done, onchip_sel, pins_owned, addr_hi_oe;
  logic addr_lo_oe, data_oe, ale_out, rd_n_out, wr_n_out, strobe_oe, off, on;
  int num_errors = 0, n_checks = 0, al;
  wire [7:0] data_in = data_oe ? data_out : dq_i;
  // Released pins fall back to their port latches, parked high.
  wire rd_pin = strobe_oe ? rd_n_out : 1'b1;
  wire wr_pin = strobe_oe ? wr_n_out : 1'b1;
  wire [7:0] a_hi_pin = addr_hi_oe ? addr_hi_out : 8'hff;
  wire [7:0] a_lo_pin = addr_lo_oe ? addr_lo_out : 8'hff;
  wire [7:0] pins_now = {pins_owned, strobe_oe, addr_hi_oe, data_oe, ale_out, rd_n_out,
    wr_n_out, external_move_instruction_done};
  logic [7:0] snap;
  always #10 pclk = ~pclk;
  emc_port_cfg u_emc_port_cfg (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .external_move_instruction_req, .external_move_instruction_write, .external_move_instruction_short,
    .external_move_instruction_addr, .external_move_instruction_wdata, .addr_hi_latch, .external_move_instruction_busy, .external_move_instruction_done, .external_move_instruction_rdata,
    .onchip_sel, .onchip_addr, .pins_owned, .addr_hi_out, .addr_hi_oe, .addr_lo_out,
    .addr_lo_oe, .data_in, .data_out, .data_oe, .ale_out, .rd_n_out, .wr_n_out, .strobe_oe);
  emc_sram_model u_emc_sram_model (.pclk, .muxed(!cfg[4]), .ale(ale_out), .rd_n(rd_pin),
    .wr_n(wr_pin), .a_hi(a_hi_pin), .a_lo(a_lo_pin), .dq_o(data_in), .dq_i,
    .last_a, .last_d);
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task results();
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task tmo();
    num_errors++;
    results();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      if (++i > 50)
        tmo();
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task mv(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    int i;
    i = 0;
    al = 0;
    on = 0;
    e = s ? {cfg[3:2] == `EMC_MODE_SPLIT_PORT ? addr_hi_latch : page, a[7:0]} : a;
    off = cfg[3:2] == `EMC_MODE_EXTERNAL || (cfg[3:2] != `EMC_MODE_INTERNAL
      && {1'b0, e} >= `EMC_ONCHIP_BYTES);
    @(posedge pclk);
    external_move_instruction_req <= 1;
    external_move_instruction_write <= w;
    external_move_instruction_short <= s;
    external_move_instruction_addr <= a;
    external_move_instruction_wdata <= d;
    do
    begin
      @(posedge pclk);
      if (external_move_instruction_busy)
        external_move_instruction_req <= 0;
      on |= onchip_sel;
      al += ale_out;
      // A low clock enable mid-move must hold the owned flag, the strobe, address-high and data enables, ALE, both strobes and done as they stand.
      if (frz && i == 3)
      begin
        clk_en <= 0;
        @(posedge pclk);
        snap = pins_now;
        repeat (2) @(posedge pclk);
        chk(pins_now, snap);
        clk_en <= 1;
      end
      if (++i > 200)
        tmo();
    end
    while (external_move_instruction_done !== 1'b1);
    chk(on, !off);
    if (off && !w)
      chk(external_move_instruction_rdata, e[7:0] ^ e[15:8]);
    if (off && w)
      chk(last_d, d);
    if (off)
    begin
      chk(last_a, e);
      chk(al, !cfg[4] ? cfg[1:0] + 32'h1 : 32'h0);
    end
    else
      chk(onchip_addr, e & (`EMC_ONCHIP_BYTES - 1));
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, `EMC_PAGE_ADDR, 0);
    chk(rd, `EMC_PAGE_RST);
    apb(0, `EMC_CFG_ADDR, 0);
    chk(rd, `EMC_CFG_RST);
    apb(0, 12'h2b0, 0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1, `EMC_CFG_ADDR, 32'hbf);
    apb(0, `EMC_CFG_ADDR, 0);
    chk(rd, 32'h1f);
    for (int k = 0; k < 48; k++)
    begin
      r = k == 0 ? 32'h0200010c : rnd();
      cfg = {3'h0, r[4:0]};
      page = r[15:8];
      frz = r[26];
      addr_hi_latch <= r[23:16];
      apb(1, `EMC_CFG_ADDR, cfg);
      apb(1, `EMC_PAGE_ADDR, page);
      apb(0, `EMC_PAGE_ADDR, 0);
      chk(rd, page);
      mv(r[24], r[25], k == 0 ? 16'h00ff : rnd(), r[31:24]);
    end
    // A second reset in mid-run must return the written page and configuration to their reset values.
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `EMC_PAGE_ADDR, 0);
    chk(rd, `EMC_PAGE_RST);
    apb(0, `EMC_CFG_ADDR, 0);
    chk(rd, `EMC_CFG_RST);
    results();
  end
endmodule
